// *** pkg/tilt_latch_pkg.sv ***
// Shared constants for the pulsed tilt sample latch
package tilt_latch_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000; // System clock rate
    localparam int unsigned SAMPLE_PERIOD_MS = 90; // Sampling period
    localparam int unsigned SELFTEST_MS = 90; // Power-up test interval
    localparam int unsigned EMIT_ON_NS = 2000; // Emitter on-time
    // Cycles per period, rounded down
    localparam int unsigned SAMPLE_PERIOD_CYC = (CLK_HZ / 1000) * SAMPLE_PERIOD_MS;
    // Self-test cycles
    localparam int unsigned SELFTEST_CYC = (CLK_HZ / 1000) * SELFTEST_MS;
    // Emitter on-time cycles, rounded up, at least one
    localparam int unsigned EMIT_ON_CYC = (EMIT_ON_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Counter width
    localparam int unsigned CNT_W = 22;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic OUT_LOW_RESET = 1'b0; // Output driver off at reset
endpackage : tilt_latch_pkg

// *** rtl/pulsed_tilt_sample_latch.sv ***
// Emitter pulsing, detector sampling and open-drain output latch
// Notes for users
// - Pin data output is tied low; the pad is driven from the enable.
// - Light and connection inputs are taken as already synchronous.
// - The first pulse keeps the test result on the pin until it samples.
// - Light seen between samples is ignored, which saves current.
// - Period and test length are parameters so a bench can shorten them.
// - Period must exceed the on-time by at least one cycle.
module pulsed_tilt_sample_latch #(
    parameter int unsigned PERIOD_CYC = tilt_latch_pkg::SAMPLE_PERIOD_CYC, // Sampling period
    parameter int unsigned SELFTEST_CYC = tilt_latch_pkg::SELFTEST_CYC // Self-test length
) (
    input wire logic clk, // System clock
    input wire logic nrst, // Power-on reset, low active
    input wire logic light_detector, // Thresholded detector, high = light
    input wire logic conn_ok, // Monitored pins connected
    output logic emitter_on, // Emitter drive
    output logic tilt_output_level_o, // Output pin value, always 0
    output logic tilt_output_level_oe // Output pull-low enable
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_TEST, ST_IDLE, ST_EMIT} phase_type;
    phase_type phase_reg; // Sequencer phase
    logic [tilt_latch_pkg::CNT_W-1:0] cnt_reg; // Period counter
    logic [tilt_latch_pkg::CNT_W-1:0] on_cyc; // On-time at counter width
    logic [tilt_latch_pkg::CNT_W-1:0] per_cyc; // Period at counter width
    logic [tilt_latch_pkg::CNT_W-1:0] test_cyc; // Test at counter width
    logic sample_end; // Last cycle of on-time
    logic emit_start; // Last cycle before a pulse begins
    logic blocked_reg; // Latched blocked state

    // ---------------------------------------------------------------
    // Timing overview
    // ---------------------------------------------------------------
    // After reset the sequencer counts out the self-test interval,
    // with the output showing the connection test result.
    // A pulse then starts: the emitter is lit for on_cyc cycles and
    // the detector is taken on the last of them only.
    // The idle phase runs the counter on to the end of the period,
    // so pulses start exactly per_cyc cycles apart.
    // The output keeps its value between samples, so the host can
    // read the pin at any time without a strobe.

    assign on_cyc = tilt_latch_pkg::CNT_W'(tilt_latch_pkg::EMIT_ON_CYC);
    assign per_cyc = tilt_latch_pkg::CNT_W'(PERIOD_CYC);
    assign test_cyc = tilt_latch_pkg::CNT_W'(SELFTEST_CYC);
    assign sample_end = (phase_reg == ST_EMIT) && (cnt_reg == on_cyc - 1'b1);
    // Pulse begins on the cycle after the test or the period runs out
    assign emit_start = (phase_reg == ST_TEST && cnt_reg == test_cyc - 1'b1) ||
        (phase_reg == ST_IDLE && cnt_reg == per_cyc - 1'b1);

    // ---------------------------------------------------------------
    // Sequencer: self-test then periodic pulses
    // ---------------------------------------------------------------
    // One counter serves test, pulse and idle; it restarts per pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_reg <= ST_TEST;
            cnt_reg <= '0;
        end
        else
        begin
            case (phase_reg)
                ST_TEST:
                begin
                    // Hold self-test interval
                    if (cnt_reg == test_cyc - 1'b1)
                    begin
                        phase_reg <= ST_EMIT;
                        cnt_reg <= '0;
                    end
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                ST_EMIT:
                begin
                    // On-time part of the period
                    if (sample_end)
                        phase_reg <= ST_IDLE;
                    cnt_reg <= cnt_reg + 1'b1;
                end
                ST_IDLE:
                begin
                    // Wait out rest of period, then pulse again
                    if (cnt_reg == per_cyc - 1'b1)
                    begin
                        phase_reg <= ST_EMIT;
                        cnt_reg <= '0;
                    end
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                default:
                begin
                    // Unused code: start over with the test
                    phase_reg <= ST_TEST;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Emitter drive
    // ---------------------------------------------------------------
    // Emitter lit from the first to the last cycle of each pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            emitter_on <= 1'b0; // Emitter dark in reset
        else if (sample_end)
            emitter_on <= 1'b0;
        else if (emit_start)
            emitter_on <= 1'b1;
        else
            emitter_on <= (phase_reg == ST_EMIT);
    end

    // ---------------------------------------------------------------
    // Sample latch
    // ---------------------------------------------------------------
    // Test result is held here so the first pulse keeps it on the pin
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            blocked_reg <= 1'b0; // Released after reset
        else if (phase_reg == ST_TEST)
            blocked_reg <= conn_ok;
        else if (sample_end)
            blocked_reg <= !light_detector;
    end

    // ---------------------------------------------------------------
    // Open-drain output driver
    // ---------------------------------------------------------------
    // Pin data is tied low; only the enable moves the pin
    // Enable high pulls the pin low, low lets the pull-up win
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tilt_output_level_oe <= tilt_latch_pkg::OUT_LOW_RESET; // Released in reset
            tilt_output_level_o <= 1'b0;
        end
        else
        begin
            tilt_output_level_o <= 1'b0;
            if (phase_reg == ST_TEST)
                tilt_output_level_oe <= conn_ok;
            else if (sample_end)
                tilt_output_level_oe <= !light_detector;
            else
                tilt_output_level_oe <= blocked_reg;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // All checks run on the system clock and rest during reset
    // Output enable checks look one cycle on, as the pin comes from a register
    chk_emit_sample: assert property (@(posedge clk) disable iff (!nrst)
        sample_end |-> emitter_on)
        else $error("sample taken with emitter off");
    chk_blocked_low: assert property (@(posedge clk) disable iff (!nrst)
        sample_end && !light_detector |=> tilt_output_level_oe)
        else $error("blocked sample did not pull low");
    chk_light_release: assert property (@(posedge clk) disable iff (!nrst)
        sample_end && light_detector |=> !tilt_output_level_oe)
        else $error("lit sample did not release");
    chk_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg == ST_IDLE) && $past(phase_reg == ST_IDLE) |-> $stable(blocked_reg))
        else $error("latch changed between samples");
    chk_period_restart: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg == ST_IDLE) && (cnt_reg == per_cyc - 1'b1) |=> phase_reg == ST_EMIT && cnt_reg == '0)
        else $error("period did not restart");
    chk_test_low: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg == ST_TEST) && conn_ok |=> tilt_output_level_oe)
        else $error("self-test did not pull low");
    chk_test_open: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg == ST_TEST) && !conn_ok |=> !tilt_output_level_oe)
        else $error("open pin test pulled low");
    chk_pin_zero: assert property (@(posedge clk) disable iff (!nrst)
        !tilt_output_level_o)
        else $error("open-drain pin driven high");
    chk_once_sample: assert property (@(posedge clk) disable iff (!nrst)
        sample_end |=> !sample_end)
        else $error("two samples in one pulse");
    // Emitter lit exactly while the sequencer is in its pulse
    chk_emit_phase: assert property (@(posedge clk) disable iff (!nrst)
        emitter_on == (phase_reg == ST_EMIT))
        else $error("emitter out of step with pulse");
    // Each pulse starts at the start of the count
    chk_pulse_start: assert property (@(posedge clk) disable iff (!nrst)
        $rose(emitter_on) |-> cnt_reg == '0)
        else $error("pulse started mid-count");
    // Self-test interval ends in a pulse
    chk_test_end: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg == ST_TEST) && (cnt_reg == test_cyc - 1'b1) |=> (phase_reg == ST_EMIT) && emitter_on)
        else $error("self-test did not end in a pulse");
    // Output moves only at a sample or during the test
    chk_out_hold: assert property (@(posedge clk) disable iff (!nrst)
        (phase_reg != ST_TEST) && !sample_end |=> $stable(tilt_output_level_oe))
        else $error("output changed between samples");
endmodule : pulsed_tilt_sample_latch

// *** test/tilt_host_model.sv ***
// Host side of the open-drain output: pull-up and pin reader
module tilt_host_model (
    input wire logic tilt_output_level_o, // Driven pin value
    input wire logic tilt_output_level_oe, // Pull-low enable
    output logic pin_level // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins when released; host reads with no strobe
    assign pin_level = tilt_output_level_oe ? tilt_output_level_o : 1'b1;
endmodule : tilt_host_model

// *** test/pulsed_tilt_sample_latch_bench.sv ***
// Self-checking bench for the pulsed tilt sample latch
module pulsed_tilt_sample_latch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PER = 200; // Short sampling period
    localparam int unsigned TST = 100; // Short self-test
    logic clk = 1'b0, nrst = 1'b0, light_detector = 1'b1, conn_ok = 1'b1; // Inputs
    logic emitter_on, tilt_output_level_o, tilt_output_level_oe, pin_level; // Outputs
    logic [31:0] seed = 32'h0000_3845; // Random state
    int err_count = 0, total_checks = 0, cycles = 0, mode = 0; // Counters, detector mode
    pulsed_tilt_sample_latch #(.PERIOD_CYC(PER), .SELFTEST_CYC(TST)) pulsed_tilt_sample_latch_i (
        .clk(clk), .nrst(nrst), .light_detector(light_detector), .conn_ok(conn_ok), .emitter_on(emitter_on),
        .tilt_output_level_o(tilt_output_level_o), .tilt_output_level_oe(tilt_output_level_oe));
    tilt_host_model tilt_host_model_i (.tilt_output_level_o(tilt_output_level_o),
        .tilt_output_level_oe(tilt_output_level_oe), .pin_level(pin_level));
    // Xorshift step
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // Expected pin: pull-up level unless the device pulls low
    function automatic logic pin_for(input logic pull_low);
        return !pull_low;
    endfunction : pin_for
    // Clock, 40 ns period
    initial
    begin
        forever #20 clk = ~clk;
    end
    // Detector stimulus: random, all blocked or all light
    always @(posedge clk)
    begin
        seed <= xorshift(seed);
        light_detector <= (mode == 0) ? seed[7] : (mode == 2);
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end
    // Compare and count
    task automatic check(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : check
    // Reset, then watch the self-test interval
    task automatic self_test(input logic conn);
        @(posedge clk);
        conn_ok <= conn;
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        repeat (TST - 4)
        begin
            @(negedge clk);
            check(pin_level, pin_for(conn), "self-test level");
            check(emitter_on, 1'b0, "emitter during test");
        end
        $display("Test self_test conn_ok=%b done", conn);
    endtask : self_test
    // One emit pulse and idle gap, checked at negedges
    task automatic one_period(input int m);
        int on_cnt, per_cnt;
        logic last, held;
        mode = m;
        on_cnt = 0;
        per_cnt = 0;
        while (emitter_on !== 1'b1 && per_cnt < 2 * PER)
        begin
            per_cnt++;
            @(negedge clk);
        end
        held = pin_level;
        while (emitter_on === 1'b1 && on_cnt < PER)
        begin
            check(pin_level, held, "level during pulse");
            last = light_detector;
            on_cnt++;
            @(negedge clk);
        end
        check(on_cnt == tilt_latch_pkg::EMIT_ON_CYC, 1'b1, "on-time");
        check(pin_level, pin_for(!last), "sampled level");
        held = pin_level;
        per_cnt = on_cnt;
        while (emitter_on !== 1'b1 && per_cnt < 2 * PER)
        begin
            check(pin_level, held, "held level");
            per_cnt++;
            @(negedge clk);
        end
        check(per_cnt == PER, 1'b1, "period");
        $display("Test one_period mode=%0d done", m);
    endtask : one_period
    // Counts and verdict
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // Main sequence
    initial
    begin
        self_test(1'b1);
        one_period(1);
        one_period(2);
        repeat (6) one_period(0);
        self_test(1'b0);
        repeat (2) one_period(0);
        end_sim();
    end
endmodule : pulsed_tilt_sample_latch_bench
